// File: verilog/abf_port.sv
// Byte FIFO port: buffers, target-side strobes and flags, APB control.
// Assumes target pins are asynchronous to pclk and the USB engine
// side runs on pclk with valid/ready streams.
//
// How it works
// - Send strobe in normal mode flushes transmit buffer
// - Flushed bytes go out on next bulk-in
// - Read strobe low drives head byte on bus
// - Read strobe high releases bus, advances buffer
// - Write strobe falling edge appends bus byte
// - Waiting bytes released within transmit timeout
// - Timeout programmable from 1 to 255 ms
// - Both flags undriven during reset
// - Available flag low when bytes wait
// - Available flag high once buffer empty
// - Suspended with wake enabled: flag pin input
// - Pin low 20 ms in suspend with wake enabled requests resume
// - Suspend indicator low only when configured, awake
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/10ps

// Synchronous FIFO with level output
module abf_fifo #(
    parameter int unsigned W = 8,
    parameter int unsigned D = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data,
    output logic [$clog2(D+1)-1:0] level
);
    localparam int unsigned AW = $clog2(D);
    logic [W-1:0] mem [D];  // Storage
    logic [AW-1:0] wr_ptr_reg;  // Next slot to fill
    logic [AW-1:0] rd_ptr_reg;  // Head slot
    logic [$clog2(D+1)-1:0] level_reg;  // Words held
    logic push;
    logic pop;

    assign in_ready = (level_reg != D[$clog2(D+1)-1:0]);
    assign out_valid = (level_reg != '0);
    assign out_data = mem[rd_ptr_reg];
    assign level = level_reg;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Storage write; no reset needed on data
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and level
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            level_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(D - 1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(D - 1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                level_reg <= level_reg + 1'b1;
            end else if (pop && !push) begin
                level_reg <= level_reg - 1'b1;
            end
        end
    end
endmodule

module abf_port
    import abf_pkg::*;
#(
    parameter int unsigned DEPTH = FIFO_DEPTH,
    parameter int unsigned CYC_PER_MS = MS_CYC,
    parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Target pins
    input wire logic rd_strobe_n,
    input wire logic wr_strobe_n,
    input wire logic send_now_wake_strobe,
    input wire logic [DATA_W-1:0] fifo_data_in,
    output logic [DATA_W-1:0] fifo_data_out,
    output logic fifo_data_oe,
    output logic tx_space_flag_n,
    output logic tx_space_flag_oe,
    input wire logic rx_available_flag_n_in,
    output logic rx_available_flag_n_out,
    output logic rx_available_flag_n_oe,
    output logic suspend_indicator_n,
    // USB engine side
    input wire logic usb_rx_valid,
    input wire logic [DATA_W-1:0] usb_rx_data,
    output logic usb_rx_ready,
    input wire logic usb_bulk_in_req,
    output logic usb_tx_valid,
    output logic [DATA_W-1:0] usb_tx_data,
    input wire logic usb_tx_ready,
    output logic usb_resume_req
);
    localparam int unsigned LW = $clog2(DEPTH + 1);

    abf_ctrl_s ctrl_reg;  // Software control
    // Pin synchronisers, two stages each
    logic [2:0] rd_sync_reg;  // [2] is previous sample for edges
    logic [2:0] wr_sync_reg;
    logic [2:0] sn_sync_reg;
    logic [1:0] wk_sync_reg;
    logic [DATA_W-1:0] din_s1_reg;
    logic [DATA_W-1:0] din_s2_reg;
    logic rd_fall, rd_rise, wr_fall, sn_fall;
    logic normal;  // Configured and awake
    logic wake_mode;  // Flag pin is an input
    // Buffer wiring
    logic rx_in_ready, rx_out_valid, rx_pop;
    logic [DATA_W-1:0] rx_head;
    logic [LW-1:0] rx_level;
    logic tx_in_ready, tx_out_valid, tx_pop;
    logic [DATA_W-1:0] tx_head;
    logic [LW-1:0] tx_level;
    // Transmit release
    logic release_reg;
    logic [31:0] ms_cnt_reg;  // Cycles within the current millisecond
    logic [7:0] age_ms_reg;  // Milliseconds bytes have waited
    logic [7:0] tmo_eff;
    logic timed_out;
    // Wake detection
    logic [31:0] wake_cnt_reg;
    logic wake_done_reg;  // One resume per low period
    // Bus outputs
    logic data_oe_reg;
    logic [DATA_W-1:0] data_out_reg;

    assign rd_fall = rd_sync_reg[2] && !rd_sync_reg[1];
    assign rd_rise = !rd_sync_reg[2] && rd_sync_reg[1];
    assign wr_fall = wr_sync_reg[2] && !wr_sync_reg[1];
    assign sn_fall = sn_sync_reg[2] && !sn_sync_reg[1];
    assign normal = ctrl_reg.configured && !ctrl_reg.suspended;
    assign wake_mode = ctrl_reg.wake_en && !normal;
    assign tmo_eff = (ctrl_reg.timeout_ms < TX_TIMEOUT_MIN_MS) ? TX_TIMEOUT_MIN_MS
                                                              : ctrl_reg.timeout_ms;
    assign timed_out = (age_ms_reg >= tmo_eff);

    // Synchronisers; stage 1 is read only by stage 2
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rd_sync_reg <= 3'h7;
            wr_sync_reg <= 3'h7;
            sn_sync_reg <= 3'h7;
            wk_sync_reg <= 2'h3;
            din_s1_reg <= '0;
            din_s2_reg <= '0;
        end else begin
            rd_sync_reg <= {rd_sync_reg[1:0], rd_strobe_n};
            wr_sync_reg <= {wr_sync_reg[1:0], wr_strobe_n};
            sn_sync_reg <= {sn_sync_reg[1:0], send_now_wake_strobe};
            wk_sync_reg <= {wk_sync_reg[0], rx_available_flag_n_in};
            din_s1_reg <= fifo_data_in;
            din_s2_reg <= din_s1_reg;
        end
    end

    // Receive buffer: host bytes toward the target
    abf_fifo #(.W(DATA_W), .D(DEPTH)) u_rx (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(usb_rx_valid && usb_rx_ready),
        .in_ready(rx_in_ready),
        .in_data(usb_rx_data),
        .out_valid(rx_out_valid),
        .out_ready(rx_pop),
        .out_data(rx_head),
        .level(rx_level)
    );
    assign rx_pop = rd_rise;

    // Transmit buffer: target bytes toward the host
    abf_fifo #(.W(DATA_W), .D(DEPTH)) u_tx (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(wr_fall),
        .in_ready(tx_in_ready),
        .in_data(din_s2_reg),
        .out_valid(tx_out_valid),
        .out_ready(tx_pop),
        .out_data(tx_head),
        .level(tx_level)
    );
    // Drain only released bytes, only while the host asks for them
    assign tx_pop = release_reg && usb_bulk_in_req && (!usb_tx_valid || usb_tx_ready);

    // Registered USB ready; one-cycle lag covered by leaving one slot spare
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_rx_ready <= 1'b0;
        end else begin
            usb_rx_ready <= (rx_level < LW'(DEPTH - 1)) && rx_in_ready;
        end
    end

    // Output stage toward the USB engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            usb_tx_valid <= 1'b0;
            usb_tx_data <= '0;
        end else if (tx_pop && tx_out_valid) begin
            usb_tx_valid <= 1'b1;
            usb_tx_data <= tx_head;
        end else if (usb_tx_ready) begin
            usb_tx_valid <= 1'b0;
        end
    end

    // Release flag: set by send strobe, timeout or a full buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            release_reg <= 1'b0;
        end else if ((sn_fall && normal) || (tx_out_valid && timed_out)) begin
            release_reg <= 1'b1;
        end else if (!tx_in_ready) begin
            release_reg <= 1'b1;
        end else if (!tx_out_valid) begin
            release_reg <= 1'b0;
        end
    end

    // Age of waiting bytes in milliseconds; restarts once drained
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ms_cnt_reg <= '0;
            age_ms_reg <= '0;
        end else if (!tx_out_valid || release_reg) begin
            ms_cnt_reg <= '0;
            age_ms_reg <= '0;
        end else if (ms_cnt_reg == CYC_PER_MS - 1) begin
            ms_cnt_reg <= '0;
            if (!timed_out) begin
                age_ms_reg <= age_ms_reg + 8'h01;
            end
        end else begin
            ms_cnt_reg <= ms_cnt_reg + 32'h1;
        end
    end

    // Data bus: drive head while read strobe low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_oe_reg <= 1'b0;
            data_out_reg <= '0;
        end else if (rd_fall) begin
            data_oe_reg <= 1'b1;
            data_out_reg <= rx_head;
        end else if (rd_rise) begin
            data_oe_reg <= 1'b0;
        end
    end
    assign fifo_data_oe = data_oe_reg;
    assign fifo_data_out = data_out_reg;

    // Flags; enables are low under reset so the pins float
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_space_flag_n <= 1'b1;
            tx_space_flag_oe <= 1'b0;
            rx_available_flag_n_out <= 1'b1;
            rx_available_flag_n_oe <= 1'b0;
            suspend_indicator_n <= 1'b1;
        end else begin
            // Goes high the cycle the write that fills the last slot is seen so the next one waits
            tx_space_flag_n <= !tx_in_ready || (wr_fall && tx_level == LW'(DEPTH - 1));
            tx_space_flag_oe <= 1'b1;
            // Forced high for one cycle at the read strobe rising edge so a pop is not hidden
            rx_available_flag_n_out <= !rx_out_valid || rd_rise;
            rx_available_flag_n_oe <= !wake_mode;
            suspend_indicator_n <= !normal;
        end
    end

    // Wake: 20 ms low on the flag pin, or a send strobe, while wake_mode is set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_cnt_reg <= '0;
            wake_done_reg <= 1'b0;
            usb_resume_req <= 1'b0;
        end else begin
            usb_resume_req <= 1'b0;
            if (!wake_mode || wk_sync_reg[1]) begin
                wake_cnt_reg <= '0;
                wake_done_reg <= 1'b0;
            end else if (wake_cnt_reg >= WAKE_CYCLES - 1) begin
                if (!wake_done_reg) begin
                    usb_resume_req <= 1'b1;
                end
                wake_done_reg <= 1'b1;
            end else begin
                wake_cnt_reg <= wake_cnt_reg + 32'h1;
            end
            if (wake_mode && sn_fall) begin
                usb_resume_req <= 1'b1;
            end
        end
    end

    // APB: one wait state, answer registered
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
            pslverr <= (paddr != CTRL_OFS) && (paddr != STATUS_OFS);
            prdata <= '0;
            if (!pwrite && paddr == CTRL_OFS) begin
                prdata[CTRL_TMO_LSB +: 8] <= ctrl_reg.timeout_ms;
                prdata[CTRL_WAKE_EN_BIT] <= ctrl_reg.wake_en;
                prdata[CTRL_CONFIG_BIT] <= ctrl_reg.configured;
                prdata[CTRL_SUSP_BIT] <= ctrl_reg.suspended;
            end else if (!pwrite && paddr == STATUS_OFS) begin
                prdata[ST_RX_AVAIL_BIT] <= rx_out_valid;
                prdata[ST_TX_FULL_BIT] <= !tx_in_ready;
                prdata[ST_TX_EMPTY_BIT] <= !tx_out_valid;
                prdata[ST_RELEASE_BIT] <= release_reg;
                prdata[ST_SUSP_BIT] <= !normal;
                prdata[ST_RX_LVL_LSB +: LW] <= rx_level;
                prdata[ST_TX_LVL_LSB +: LW] <= tx_level;
            end
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // Control register write at the completing edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RESET;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
            ctrl_reg.timeout_ms <= pwdata[CTRL_TMO_LSB +: 8];
            ctrl_reg.wake_en <= pwdata[CTRL_WAKE_EN_BIT];
            ctrl_reg.configured <= pwdata[CTRL_CONFIG_BIT];
            ctrl_reg.suspended <= pwdata[CTRL_SUSP_BIT];
        end
    end
endmodule

// File: verilog/abf_pkg.sv
// Shared constants and carriers for the byte FIFO port.
// Assumes a single 250 MHz APB clock domain for all users.
package abf_pkg;
    // Clock rate and derived millisecond count
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned MS_CYC = CLK_HZ / MS_PER_S;
    // Transmit release timeout, whole milliseconds
    localparam logic [7:0] TX_TIMEOUT_DEF_MS = 8'h10;
    localparam logic [7:0] TX_TIMEOUT_MIN_MS = 8'h01;
    // Least low time on the wake pin, in milliseconds
    localparam int unsigned WAKE_MIN_MS = 20;
    localparam int unsigned WAKE_CYC = WAKE_MIN_MS * MS_CYC;
    // Buffer shape
    localparam int unsigned DATA_W = 8;
    localparam int unsigned FIFO_DEPTH = 16;
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    // Control field positions
    localparam int unsigned CTRL_TMO_LSB = 0;
    localparam int unsigned CTRL_WAKE_EN_BIT = 8;
    localparam int unsigned CTRL_CONFIG_BIT = 9;
    localparam int unsigned CTRL_SUSP_BIT = 10;
    // Status field positions
    localparam int unsigned ST_RX_AVAIL_BIT = 0;
    localparam int unsigned ST_TX_FULL_BIT = 1;
    localparam int unsigned ST_TX_EMPTY_BIT = 2;
    localparam int unsigned ST_RELEASE_BIT = 3;
    localparam int unsigned ST_SUSP_BIT = 4;
    localparam int unsigned ST_RX_LVL_LSB = 8;
    localparam int unsigned ST_TX_LVL_LSB = 16;
    // Control register contents
    typedef struct packed {
        logic suspended;
        logic configured;
        logic wake_en;
        logic [7:0] timeout_ms;
    } abf_ctrl_s;
    localparam abf_ctrl_s CTRL_RESET = '{suspended: 1'b0, configured: 1'b0,
                                         wake_en: 1'b0, timeout_ms: TX_TIMEOUT_DEF_MS};
endpackage

// File: verification/abf_port_asserts.sv
// Port-level checker for the byte FIFO port, bound to abf_port.
// Assumes one pclk domain; control bits are mirrored from APB writes.
`timescale 1ns/10ps
module abf_port_asserts
    import abf_pkg::*;
#(
    parameter int unsigned WAKE_CYCLES = WAKE_CYC
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic rd_strobe_n,
    input wire logic fifo_data_oe,
    input wire logic tx_space_flag_oe,
    input wire logic rx_available_flag_n_in,
    input wire logic rx_available_flag_n_out,
    input wire logic rx_available_flag_n_oe,
    input wire logic suspend_indicator_n,
    input wire logic usb_rx_valid,
    input wire logic usb_rx_ready,
    input wire logic usb_resume_req
);
    logic wake_en_reg; // Mirror of the wake enable bit
    logic normal_reg; // Configured and not suspended
    logic seen_reg; // Resume pulse seen in this low stretch
    logic [15:0] low_cnt_reg; // Wake pin low time, saturating
    logic wake_mode;
    assign wake_mode = wake_en_reg && !normal_reg;
    // Mirror control writes at the edge they complete
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_en_reg <= 1'b0;
            normal_reg <= 1'b0;
        end else if (psel && penable && pready && pwrite && paddr == CTRL_OFS) begin
            wake_en_reg <= pwdata[CTRL_WAKE_EN_BIT];
            normal_reg <= pwdata[CTRL_CONFIG_BIT] && !pwdata[CTRL_SUSP_BIT];
        end
    end
    // Saturate so a long hold never wraps back past the limit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_cnt_reg <= 16'h0000;
        end else if (!(wake_mode && !rx_available_flag_n_in)) begin
            low_cnt_reg <= 16'h0000;
        end else if (low_cnt_reg < 16'(WAKE_CYCLES + 8)) begin
            low_cnt_reg <= low_cnt_reg + 16'h0001;
        end
    end
    // Latch a resume pulse; cleared when the pin lets go
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_reg <= 1'b0;
        end else if (low_cnt_reg == 16'h0000) begin
            seen_reg <= 1'b0;
        end else if (usb_resume_req) begin
            seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_rd_low; (!rd_strobe_n)[*5]; endsequence
    sequence s_rd_high; rd_strobe_n[*5]; endsequence
    sequence s_wake_held; wake_mode[*3]; endsequence
    sequence s_norm_steady; $stable(normal_reg)[*3]; endsequence
    chk_reset_float: assert property (disable iff (1'b0)
        !presetn |-> !fifo_data_oe && !tx_space_flag_oe && !rx_available_flag_n_oe)
        else $error("pins driven in reset");
    chk_read_drive: assert property (s_rd_low |-> fifo_data_oe)
        else $error("bus not driven during read");
    chk_read_release: assert property (s_rd_high |-> !fifo_data_oe)
        else $error("bus not released");
    chk_rx_flag_low: assert property (
        usb_rx_valid && usb_rx_ready && rd_strobe_n && !wake_mode
        |-> ##[1:4] !rx_available_flag_n_out) else $error("rx flag stays high");
    chk_wake_float: assert property (s_wake_held |-> !rx_available_flag_n_oe)
        else $error("flag pin driven in wake mode");
    chk_susp_level: assert property (
        s_norm_steady |-> suspend_indicator_n == !normal_reg)
        else $error("suspend indicator wrong");
    chk_resume_due: assert property (
        low_cnt_reg == 16'(WAKE_CYCLES + 6) |-> seen_reg) else $error("no resume");
    chk_resume_cause: assert property ($rose(usb_resume_req) |-> wake_mode)
        else $error("resume outside wake mode");
    chk_err_ready: assert property (pslverr |-> pready) else $error("lone slave error");
endmodule
bind abf_port abf_port_asserts #(.WAKE_CYCLES(WAKE_CYCLES)) u_chk (.*);

// File: verification/abf_target_model.sv
// Target controller model driving the byte FIFO pins.
// Assumes the port's enables; resolves the shared pins here.
`timescale 1ns/10ps
module abf_target_model (
    input wire logic pclk,
    input wire logic [7:0] fifo_data_out,
    input wire logic fifo_data_oe,
    input wire logic tx_space_flag_n,
    input wire logic rx_available_flag_n_out,
    input wire logic rx_available_flag_n_oe,
    output logic rd_strobe_n,
    output logic wr_strobe_n,
    output logic send_now_wake_strobe,
    output logic [7:0] fifo_data_in,
    output logic rx_available_flag_n_in
);
    logic [7:0] drv_data = 8'h00; // Byte we place on the bus
    logic drv_en = 1'b0; // High while we drive the bus
    logic pin_low = 1'b0; // High while we pull the flag pin
    logic [7:0] idle = 8'h5A; // Floating bus, never a stale byte
    int hold = 1; // Idle cycles after a strobe; raise for a slow target
    initial begin
        rd_strobe_n = 1'b1;
        wr_strobe_n = 1'b1;
        send_now_wake_strobe = 1'b1;
    end
    always @(posedge pclk) idle <= ~idle;
    assign fifo_data_in = fifo_data_oe ? fifo_data_out : (drv_en ? drv_data : idle);
    // Flag pin has a pull-up when nobody drives it
    assign rx_available_flag_n_in = rx_available_flag_n_oe ? rx_available_flag_n_out : !pin_low;
    // Waits for space, then strobes high to low with data held around it
    task automatic write_byte(input logic [7:0] d);
        int n;
        n = 0;
        while (tx_space_flag_n !== 1'b0 && n < 200) begin
            @(posedge pclk);
            n++;
        end
        if (n < 200) begin
            @(posedge pclk);
            drv_en <= 1'b1;
            drv_data <= d;
            repeat (4) @(posedge pclk);
            wr_strobe_n <= 1'b0;
            repeat (4) @(posedge pclk);
            wr_strobe_n <= 1'b1;
            drv_en <= 1'b0;
            repeat (hold) @(posedge pclk);
        end
    endtask
    task automatic read_byte(output logic [7:0] d);
        @(posedge pclk);
        rd_strobe_n <= 1'b0;
        repeat (5) @(posedge pclk);
        d = fifo_data_in;
        rd_strobe_n <= 1'b1;
        repeat (4 + hold) @(posedge pclk);
    endtask
    task automatic send_now();
        @(posedge pclk);
        send_now_wake_strobe <= 1'b0;
        repeat (4) @(posedge pclk);
        send_now_wake_strobe <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic wake_hold(input int n);
        @(posedge pclk);
        pin_low <= 1'b1;
        repeat (n) @(posedge pclk);
        pin_low <= 1'b0;
    endtask
endmodule

// File: verification/abf_port_tb.sv
// Self-checking bench for the byte FIFO port with a target model.
// Assumes shortened millisecond and wake counts to keep runs short.
`timescale 1ns/10ps
module abf_port_tb;
    import abf_pkg::*;
    localparam int unsigned CPM = 10; // Cycles per millisecond here
    localparam int unsigned WK = 50; // Wake hold cycles here
    logic pclk = 1'b0, presetn = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic pready, pslverr, rd_strobe_n, wr_strobe_n, send_now_wake_strobe;
    logic [7:0] fifo_data_in, fifo_data_out, usb_tx_data, usb_rx_data = 8'h00;
    logic fifo_data_oe, tx_space_flag_n, tx_space_flag_oe, suspend_indicator_n;
    logic rx_available_flag_n_in, rx_available_flag_n_out, rx_available_flag_n_oe;
    logic usb_rx_valid = 1'b0, usb_bulk_in_req = 1'b1, usb_tx_ready = 1'b0;
    logic usb_rx_ready, usb_tx_valid, usb_resume_req;
    logic [7:0] tx_q[$]; // Bytes seen leaving toward the host
    int error_cnt = 0, total_checks = 0, res_cnt = 0;
    abf_port #(.CYC_PER_MS(CPM), .WAKE_CYCLES(WK)) DUT (.*);
    abf_target_model tgt (.*);
    always #2 pclk = ~pclk;
    // Host side stalls every other cycle
    always @(posedge pclk) usb_tx_ready <= ~usb_tx_ready;
    // Sample at the falling edge so the next rising edge is known
    always @(negedge pclk) begin
        if (usb_tx_valid && usb_tx_ready) tx_q.push_back(usb_tx_data);
        if (usb_resume_req) res_cnt++;
    end
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    // One APB transfer; waits for pready and holds the request until it
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        // Sampled right at the rising edge, before the slave updates
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) error_cnt++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic usb_push(input logic [7:0] d);
        @(posedge pclk);
        usb_rx_valid <= 1'b1;
        usb_rx_data <= d;
        do @(posedge pclk); while (usb_rx_ready !== 1'b1);
        usb_rx_valid <= 1'b0;
    endtask
    task automatic wait_tx(input int n, input int lim);
        for (int i = 0; i < lim && tx_q.size() < n; i++) @(posedge pclk);
        check(32'(tx_q.size()), 32'(n));
    endtask
    task automatic t_regs();
        logic [31:0] r;
        logic e;
        apb(1'b0, CTRL_OFS, 32'h0, r, e);
        check(r, 32'h0000_0010);
        apb(1'b1, 8'h08, 32'h0000_0301, r, e);
        check(32'(e), 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0000_0210, r, e);
        repeat (4) @(posedge pclk);
        check(32'(suspend_indicator_n), 32'h0);
    endtask
    task automatic t_rx();
        logic [7:0] d;
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 3; i++) usb_push(8'hA0 + 8'(i));
        repeat (6) @(posedge pclk);
        check(32'(rx_available_flag_n_in), 32'h0);
        // Status: three bytes waiting, transmit side empty, link normal
        apb(1'b0, STATUS_OFS, 32'h0, r, e);
        check(r, 32'h0000_0305);
        for (int i = 0; i < 3; i++) begin
            d = 8'hXX;
            if (rx_available_flag_n_in === 1'b0) tgt.read_byte(d);
            check(32'(d), 32'hA0 + 32'(i));
            check(32'(fifo_data_oe), 32'h0);
        end
        check(32'(rx_available_flag_n_in), 32'h1);
    endtask
    task automatic t_fill();
        usb_bulk_in_req <= 1'b0;
        for (int i = 0; i < 17; i++) tgt.write_byte(8'h30 + 8'(i));
        check(32'(tx_space_flag_n), 32'h1);
        tx_q.delete();
        usb_bulk_in_req <= 1'b1;
        wait_tx(16, 400);
        foreach (tx_q[i]) check(32'(tx_q[i]), 32'h30 + 32'(i));
        check(32'(tx_space_flag_n), 32'h0);
    endtask
    task automatic t_send();
        logic [31:0] r;
        logic e;
        apb(1'b1, CTRL_OFS, 32'h0000_02FF, r, e);
        tx_q.delete();
        tgt.write_byte(8'h5C);
        tgt.write_byte(8'hC5);
        check(32'(tx_q.size()), 32'h0);
        tgt.send_now();
        wait_tx(2, 40);
        check(32'(tx_q[1]), 32'hC5);
    endtask
    task automatic t_timeout();
        int ms[3] = '{1, 16, 255};
        logic [31:0] r;
        logic e;
        foreach (ms[k]) begin
            apb(1'b1, CTRL_OFS, 32'h0000_0200 | 32'(ms[k]), r, e);
            tx_q.delete();
            tgt.write_byte(8'h11);
            repeat (ms[k] * CPM - 6) @(posedge pclk);
            check(32'(tx_q.size()), 32'h0);
            wait_tx(1, 30);
        end
    endtask
    task automatic t_wake();
        logic [31:0] r;
        logic e;
        apb(1'b1, CTRL_OFS, 32'h0000_0710, r, e);
        repeat (4) @(posedge pclk);
        check(32'(suspend_indicator_n), 32'h1);
        check(32'(rx_available_flag_n_oe), 32'h0);
        res_cnt = 0;
        tgt.wake_hold(WK - 10);
        repeat (6) @(posedge pclk);
        check(32'(res_cnt), 32'h0);
        tgt.wake_hold(WK + 10);
        repeat (6) @(posedge pclk);
        check(32'(res_cnt), 32'h1);
        apb(1'b1, CTRL_OFS, 32'h0000_0210, r, e);
        repeat (4) @(posedge pclk);
        check(32'(rx_available_flag_n_oe), 32'h1);
    endtask
    task automatic give_verdict();
        $display("Checks %0d, errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        // Falling edge at time zero so every flop starts in reset
        presetn <= 1'b0;
        repeat (6) @(posedge pclk);
        check(32'({fifo_data_oe, tx_space_flag_oe, rx_available_flag_n_oe}), 32'h0);
        presetn <= 1'b1;
        t_regs();
        t_rx();
        t_fill();
        t_send();
        t_timeout();
        t_wake();
        give_verdict();
    end
    // Whole run needs well under 8000 cycles
    initial begin
        repeat (20000) @(posedge pclk);
        error_cnt++;
        give_verdict();
    end
endmodule
